// ===== dv/fault_log_sva.sv
// Port checker of the fault summary and history block
`include "fault_log_regs.svh"
module fault_log_sva (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Fault levels and access request
    input wire logic general_fault_in,
    input wire logic temperature_fault_in,
    input wire logic od_req_in,
    input wire logic od_write_in,
    input wire logic [15:0] od_index_in,
    input wire logic [7:0] od_subindex_in,
    // Answers and summary
    input wire logic od_ack_out,
    input wire logic od_abort_out,
    input wire logic [31:0] od_rdata_out,
    input wire logic [7:0] fault_summary_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////
    // Decoded requests, kept apart so each property stays short
    wire sum_rd = od_req_in && !od_write_in && od_index_in == `FAULT_SUMMARY_INDEX && od_subindex_in == 8'h00;
    wire cnt_wr = od_req_in && od_write_in && od_index_in == `FAULT_HISTORY_INDEX && od_subindex_in == 8'h00;
    // Access answers
    ack_follows_req_a: assert property (od_req_in |=> od_ack_out)
        else $error("no answer one cycle after a request");
    ack_without_req_a: assert property (!od_req_in |=> !od_ack_out)
        else $error("answer without a request");
    abort_needs_ack_a: assert property (od_abort_out |-> od_ack_out && od_rdata_out == 32'h0)
        else $error("abort without answer or with data");
    summary_read_a: assert property (sum_rd |=> !od_abort_out
        && od_rdata_out == {24'h0, $past(fault_summary_out)})
        else $error("summary read gives wrong data");
    count_write_a: assert property (cnt_wr |=> od_ack_out && !od_abort_out)
        else $error("count write refused");
    // Summary bits follow live faults
    reserved_zero_a: assert property (fault_summary_out[`RESERVED_ZERO_BIT] == 1'b0)
        else $error("reserved summary bit set");
    general_set_a: assert property (general_fault_in |=> fault_summary_out[`GENERAL_FAULT_BIT])
        else $error("general bit not set");
    temp_clear_a: assert property (!temperature_fault_in |=> !fault_summary_out[`TEMPERATURE_FAULT_BIT])
        else $error("temperature bit not cleared");
    cover property (cnt_wr);
    cover property (od_abort_out);
    cover property (sum_rd ##1 od_rdata_out != 32'h0);
endmodule : fault_log_sva

// ===== dv/tb_top.sv
// Self-checking bench of the fault summary and history block
module tb_top import fault_log_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [15:0] idx; logic [7:0] sub; logic [31:0] wd;
        logic ab; logic [31:0] v;} row_t;
    logic ref_clk_in = 1'b0, reset_in = 1'b1, fault_push_in = 1'b0, od_req_in = 1'b0, od_write_in = 1'b0;
    logic od_ack_out, od_abort_out;
    logic [7:0] flt = 8'h00, fault_number_in = 8'h00, od_subindex_in = 8'h00, fault_summary_out;
    logic [15:0] fault_code_in = 16'h0000, od_index_in = 16'h0000;
    logic [31:0] od_wdata_in = 32'h0, od_rdata_out, od_abort_code_out;
    int miscompares = 0, cmp_count = 0;
    // Ordinary accesses after reset: read, refused and ignored cases
    row_t rows [9] = '{'{0, 16'h1003, 8'h00, 0, 0, 0}, '{0, 16'h1003, 8'h01, 0, 1, 32'h08000024},
        '{0, 16'h1003, 8'h08, 0, 1, 32'h08000024}, '{1, 16'h1001, 8'h00, 5, 1, 32'h06020000},
        '{1, 16'h1003, 8'h01, 5, 1, 32'h06020000}, '{0, 16'h1003, 8'h09, 0, 1, 32'h06020000},
        '{0, 16'h1001, 8'h00, 0, 0, 0}, '{1, 16'h1003, 8'h00, 3, 0, 0}, '{0, 16'h1003, 8'h00, 0, 0, 0}};
    error_register_and_history_stack u_dut (.ref_clk_in, .reset_in, .general_fault_in(flt[0]),
        .current_fault_in(flt[1]), .voltage_fault_in(flt[2]), .temperature_fault_in(flt[3]),
        .communication_fault_in(flt[4]), .profile_fault_in(flt[5]), .vendor_fault_in(flt[7]),
        .fault_push_in, .fault_number_in, .fault_code_in, .od_req_in, .od_write_in, .od_index_in,
        .od_subindex_in, .od_wdata_in, .od_ack_out, .od_abort_out, .od_rdata_out, .od_abort_code_out,
        .fault_summary_out);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One access; answer sampled once the answering edge has landed
    task automatic acc(input row_t r);
        @(posedge ref_clk_in);
        #1;
        {od_req_in, od_write_in, od_index_in, od_subindex_in, od_wdata_in} = {1'b1, r.w, r.idx, r.sub, r.wd};
        @(posedge ref_clk_in);
        #1;
        od_req_in = 1'b0;
        chk({31'h0, od_ack_out}, 32'h1);
        chk({31'h0, od_abort_out}, {31'h0, r.ab});
        chk(r.ab ? od_abort_code_out : od_rdata_out, r.v);
    endtask : acc
    // Fault levels change with the push, so the class byte sees them live
    task automatic push(input logic [7:0] n);
        @(posedge ref_clk_in);
        #1;
        {flt, fault_push_in, fault_number_in, fault_code_in} = {n, 1'b1, n, 16'h1000 + 16'(n)};
        @(posedge ref_clk_in);
        #1;
        fault_push_in = 1'b0;
    endtask : push
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    // Clock
    initial
    begin
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (3000) @(posedge ref_clk_in);
        miscompares++;
        final_report();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(posedge ref_clk_in);
        #1;
        reset_in = 1'b0;
        foreach (rows[i]) acc(rows[i]);
        for (int n = 1; n <= 9; n++) push(8'(n));
        acc('{0, 16'h1003, 8'h00, 0, 0, 32'h8});
        // Nine pushes: slot k holds push 10-k, the first one dropped
        for (int k = 1; k <= 8; k++)
            acc('{0, 16'h1003, 8'(k), 0, 0, {8'(10 - k), 8'(10 - k), 16'h1000 + 16'(10 - k)}});
        for (int b = 0; b < 8; b++)
        begin
            flt = 8'h01 << b;
            acc('{0, 16'h1001, 8'h00, 0, 0, {24'h0, flt & 8'hBF}});
        end
        flt = 8'h00;
        acc('{0, 16'h1001, 8'h00, 0, 0, 0});
        acc('{1, 16'h1003, 8'h00, 0, 0, 0});
        acc('{0, 16'h1003, 8'h00, 0, 0, 0});
        acc('{0, 16'h1003, 8'h01, 0, 1, 32'h08000024});
        push(8'h2A);
        acc('{0, 16'h1003, 8'h01, 0, 0, 32'h2A2A102A});
        acc('{0, 16'h1003, 8'h00, 0, 0, 32'h1});
        // Second reset in mid-run with a fault still present
        reset_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        reset_in = 1'b0;
        chk({24'h0, fault_summary_out}, 32'h0);
        flt = 8'h00;
        acc('{0, 16'h1003, 8'h00, 0, 0, 0});
        acc('{0, 16'h1003, 8'h02, 0, 1, 32'h08000024});
        final_report();
    end
endmodule : tb_top
bind error_register_and_history_stack fault_log_sva u_sva (.ref_clk_in, .reset_in, .general_fault_in,
    .temperature_fault_in, .od_req_in, .od_write_in, .od_index_in, .od_subindex_in, .od_ack_out,
    .od_abort_out, .od_rdata_out, .fault_summary_out);

// ===== rtl/error_register_and_history_stack.sv
// Fault summary register and eight-deep fault history stack
`include "fault_log_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1: A summary bit is high for as long as its matching fault input is present.
// RQ2: A summary bit drops by itself once its fault input goes away, with no write needed.
// RQ3: The summary holds general, current, voltage, temperature, communication, profile, zero, vendor in bits 0 to 7.
// RQ4: The history keeps at most eight records of 32 bits each.
// RQ5: A newly detected fault is written into slot 1.
// RQ6: On insertion slots 1 to 7 move down one place and the oldest record is dropped.
// RQ7: Subindex 0 of the history object reads the number of recorded faults.
// RQ8: Reading slots 1 to 8 while the history is empty aborts with code 08000024.
// RQ9: Writing zero to the count restarts counting from the beginning.
// RQ10: A record holds the error number in bits 31 to 24, class in 23 to 16 and code in 15 to 0.
// RQ11: The class byte of a record equals the summary at the moment of recording.
// RQ12: The count rises by one per fault, stops at eight, and nonzero writes are ignored.
// RQ13: After reset the summary and count read zero, every slot register clears to zero and the history is empty.
module error_register_and_history_stack
    import fault_log_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Live fault conditions, one per summary category
    input wire logic general_fault_in,
    input wire logic current_fault_in,
    input wire logic voltage_fault_in,
    input wire logic temperature_fault_in,
    input wire logic communication_fault_in,
    input wire logic profile_fault_in,
    input wire logic vendor_fault_in,
    // New fault report, one-cycle strobe with its number and code
    input wire logic fault_push_in,
    input wire logic [7:0] fault_number_in,
    input wire logic [15:0] fault_code_in,
    // Object dictionary access, one-cycle request
    input wire logic od_req_in,
    input wire logic od_write_in,
    input wire logic [15:0] od_index_in,
    input wire logic [7:0] od_subindex_in,
    input wire logic [31:0] od_wdata_in,
    // Object dictionary answer, one cycle after the request
    output logic od_ack_out,
    output logic od_abort_out,
    output logic [31:0] od_rdata_out,
    output logic [31:0] od_abort_code_out,
    // Live summary
    output logic [7:0] fault_summary_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    fault_summary_t summary_q;
    fault_summary_t summary_d;
    fault_count_t count_q;
    fault_count_t count_d;
    fault_record_t slot_q [`FAULT_HISTORY_DEPTH];
    fault_record_t slot_d [`FAULT_HISTORY_DEPTH];
    logic ack_q;
    logic ack_d;
    logic abort_q;
    logic abort_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] abort_code_q;
    logic [31:0] abort_code_d;
    fault_summary_t live_summary;
    logic count_clear;

    // Slot subindex in range 1 to 8
    function automatic logic is_slot(input logic [7:0] sub);
        is_slot = (sub != `FAULT_COUNT_SUBINDEX) && (sub <= `FAULT_LAST_SUBINDEX);
    endfunction : is_slot

    ////////////////////////////////////////////////////////////////////////////
    // Summary follows live faults; registered for the output, while the record takes the live value
    always_comb
    begin
        live_summary = `FAULT_SUMMARY_RESET;
        live_summary[`GENERAL_FAULT_BIT] = general_fault_in; // [RQ1] [RQ3]
        live_summary[`CURRENT_FAULT_BIT] = current_fault_in; // [RQ3]
        live_summary[`VOLTAGE_FAULT_BIT] = voltage_fault_in; // [RQ3]
        live_summary[`TEMPERATURE_FAULT_BIT] = temperature_fault_in; // [RQ3]
        live_summary[`COMMUNICATION_FAULT_BIT] = communication_fault_in; // [RQ3]
        live_summary[`PROFILE_FAULT_BIT] = profile_fault_in; // [RQ3]
        live_summary[`RESERVED_ZERO_BIT] = 1'b0; // [RQ3]
        live_summary[`VENDOR_FAULT_BIT] = vendor_fault_in; // [RQ3]
        summary_d = live_summary; // No sticky hold, bits fall with the fault [RQ2]
    end

    ////////////////////////////////////////////////////////////////////////////
    // History stack and count
    always_comb
    begin
        count_clear = od_req_in && od_write_in && (od_index_in == `FAULT_HISTORY_INDEX)
            && (od_subindex_in == `FAULT_COUNT_SUBINDEX) && (od_wdata_in == 32'h00000000);
        count_d = count_q;
        for (int i = 0; i < `FAULT_HISTORY_DEPTH; i++)
        begin
            slot_d[i] = slot_q[i];
        end
        if (count_clear)
        begin
            count_d = 4'(`FAULT_COUNT_RESET); // Restart counting [RQ9]
        end
        // Push after clear so a fault in the same cycle is counted, not lost
        if (fault_push_in)
        begin
            for (int i = `FAULT_HISTORY_DEPTH - 1; i > 0; i--)
            begin
                slot_d[i] = slot_q[i - 1]; // Oldest falls off the end [RQ6] [RQ4]
            end
            slot_d[0] = {fault_number_in, live_summary, fault_code_in}; // [RQ5] [RQ10] [RQ11]
            if (count_d < 4'(`FAULT_HISTORY_DEPTH))
            begin
                count_d = count_d + 4'h1; // Saturates at eight [RQ12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access decode; answer lands one cycle after the request
    always_comb
    begin
        ack_d = od_req_in;
        abort_d = 1'b0;
        abort_code_d = 32'h00000000;
        rdata_d = 32'h00000000;
        if (od_req_in)
        begin
            if (od_index_in == `FAULT_SUMMARY_INDEX && od_subindex_in == 8'h00 && !od_write_in)
            begin
                rdata_d = {24'h000000, summary_q};
            end
            else if (od_index_in == `FAULT_HISTORY_INDEX && od_subindex_in == `FAULT_COUNT_SUBINDEX)
            begin
                // Nonzero writes are silently dropped [RQ12]
                rdata_d = od_write_in ? 32'h00000000 : {28'h0000000, count_q}; // [RQ7]
            end
            else if (od_index_in == `FAULT_HISTORY_INDEX && is_slot(od_subindex_in) && !od_write_in)
            begin
                if (count_q == 4'h0)
                begin
                    abort_d = 1'b1; // Empty history refuses slot reads [RQ8]
                    abort_code_d = `ABORT_NO_RECORD;
                end
                else
                begin
                    rdata_d = slot_q[3'(od_subindex_in - 8'h01)];
                end
            end
            else
            begin
                abort_d = 1'b1; // Read-only object written or unknown entry
                abort_code_d = `ABORT_NO_OBJECT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Summary register; clears to zero even while a fault is still present [RQ13]
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            summary_q <= `FAULT_SUMMARY_RESET;
        end
        else
        begin
            summary_q <= summary_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // History registers; reset leaves an empty history of zero slots [RQ13]
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            count_q <= 4'(`FAULT_COUNT_RESET);
            for (int i = 0; i < `FAULT_HISTORY_DEPTH; i++)
            begin
                slot_q[i] <= `FAULT_RECORD_RESET;
            end
        end
        else
        begin
            count_q <= count_d;
            for (int i = 0; i < `FAULT_HISTORY_DEPTH; i++)
            begin
                slot_q[i] <= slot_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer registers; a reset in mid-access drops the pending answer,
    // so the master has to repeat any request it made during reset
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            ack_q <= 1'b0;
            abort_q <= 1'b0;
            rdata_q <= 32'h00000000;
            abort_code_q <= 32'h00000000;
        end
        else
        begin
            ack_q <= ack_d;
            abort_q <= abort_d;
            rdata_q <= rdata_d;
            abort_code_q <= abort_code_d;
        end
    end

    // Outputs straight from flip-flops
    assign od_ack_out = ack_q;
    assign od_abort_out = abort_q;
    assign od_rdata_out = rdata_q;
    assign od_abort_code_out = abort_code_q;
    assign fault_summary_out = summary_q;

endmodule : error_register_and_history_stack

// ===== rtl/fault_log_pkg.sv
// Types shared by the fault summary and history block
package fault_log_pkg;

    typedef logic [7:0] fault_summary_t;
    typedef logic [31:0] fault_record_t;
    typedef logic [3:0] fault_count_t;

endpackage : fault_log_pkg

// ===== rtl/fault_log_regs.svh
// Offsets, field positions and reset values of the fault summary and history block
`ifndef FAULT_LOG_REGS_SVH
`define FAULT_LOG_REGS_SVH

// Object indices
`define FAULT_SUMMARY_INDEX 16'h1001
`define FAULT_HISTORY_INDEX 16'h1003
// Subindex of the count inside the history object
`define FAULT_COUNT_SUBINDEX 8'h00
// Highest history slot subindex
`define FAULT_LAST_SUBINDEX 8'h08
// Summary bit positions
`define GENERAL_FAULT_BIT 0
`define CURRENT_FAULT_BIT 1
`define VOLTAGE_FAULT_BIT 2
`define TEMPERATURE_FAULT_BIT 3
`define COMMUNICATION_FAULT_BIT 4
`define PROFILE_FAULT_BIT 5
`define RESERVED_ZERO_BIT 6
`define VENDOR_FAULT_BIT 7
// Record field positions
`define RECORD_NUMBER_LSB 24
`define RECORD_CLASS_LSB 16
`define RECORD_CODE_LSB 0
// History depth and reset values
`define FAULT_HISTORY_DEPTH 8
`define FAULT_COUNT_RESET 8'h00
`define FAULT_SUMMARY_RESET 8'h00
`define FAULT_RECORD_RESET 32'h00000000
// Abort code for a slot read while the history is empty
`define ABORT_NO_RECORD 32'h08000024
// Abort code for any other refused access
`define ABORT_NO_OBJECT 32'h06020000

`endif
